// ===== design/asr_ctrl_regs.vh
// Timing constants for the asynchronous 256K x 16 static memory controller.
// Assumes a 25 MHz system clock (40 ns period).
`ifndef ASR_CTRL_REGS_VH
`define ASR_CTRL_REGS_VH

`define ASR_CLK_PERIOD_NS 40
// Device timing figures in ns
`define ASR_T_RC_NS 12
`define ASR_T_WC_NS 12
`define ASR_T_AA_NS 12
`define ASR_T_ACE_NS 12
`define ASR_T_DOE_NS 6
`define ASR_T_DBE_NS 6
`define ASR_T_HZ_NS 6
`define ASR_T_PD_NS 12
`define ASR_T_SCE_NS 10
`define ASR_T_AW_NS 10
`define ASR_T_BW_NS 10
`define ASR_T_PWE_NS 10
`define ASR_T_SD_NS 7
`define ASR_T_HZWE_NS 6
// Derived cycle counts: every time rounds up to whole cycles, floor one cycle
`define ASR_CYC_UP(ns) ((((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS))
// Read access: wait the address access delay only
`define ASR_RD_CYC `ASR_CYC_UP(`ASR_T_AA_NS)
// Write strobe low time is the sum of pulse width and turn-off; lane select, address and data setup are not added
`define ASR_WR_CYC `ASR_CYC_UP(`ASR_T_PWE_NS + `ASR_T_HZWE_NS)
// Bus turnaround after the controller stops driving, before output drive falls
`define ASR_TURN_CYC `ASR_CYC_UP(`ASR_T_HZ_NS)
`define ASR_CYCLE_CYC `ASR_CYC_UP(`ASR_T_WC_NS)
`define ASR_CNT_W 3

`endif

// ===== design/asr_ctrl.v
// Host-side controller for an asynchronous 256K x 16 static memory with byte lanes.
// Assumes the memory pins are wired straight to the ports; data_bus is split into in, out and enable.
// Assumes an external tri-state buffer that drives the pins while data_bus_oe_n is low.
// Read data on lanes that were not selected is returned as zero.
`timescale 1ns/1ps
`include "asr_ctrl_regs.vh"

// Overview of operation
// - Controller times data setup and hold against the terminating edge.
// - Strobe-controlled writes keep output drive high and last pulse width plus turn-off.
// - Controller holds write address at least 10 ns before write end.
// - Controller keeps address unchanged until write ends.
// - Controller has address valid by the start of the write.
// - Controller drives write data at least 7 ns before the terminating edge.
// - Controller asserts lane select at least 10 ns before write end.
module asr_ctrl (
  input wire clk_sys,
  input wire reset,
  input wire clk_en,
  input wire req_valid,
  input wire req_write,
  input wire [17:0] req_addr,
  input wire [15:0] req_wdata,
  input wire [1:0] req_be,
  output wire req_ready,
  output reg rsp_valid,
  output reg [15:0] rsp_rdata,
  output reg [17:0] mem_addr,
  output reg chip_select_n,
  output reg output_drive_n,
  output reg write_strobe_n,
  output reg low_byte_select_n,
  output reg high_byte_select_n,
  input wire [15:0] data_bus_in,
  output reg [15:0] data_bus_out,
  output reg data_bus_oe_n
);

  // Write path: IDLE, WSETUP, WSTROBE, WEND
  // Read path: IDLE, RTURN, RWAIT, REND
  // The strobe only ever falls one cycle after select and address settle
  localparam ST_IDLE = 3'h0;
  localparam ST_WSETUP = 3'h1;
  localparam ST_WSTROBE = 3'h2;
  localparam ST_WEND = 3'h3;
  localparam ST_RTURN = 3'h4;
  localparam ST_RWAIT = 3'h5;
  localparam ST_REND = 3'h6;

  // Cycle counts worked out at full width, then cut to the counter width
  localparam integer RD_CYC_INT = `ASR_RD_CYC;
  localparam integer WR_CYC_INT = `ASR_WR_CYC;
  localparam integer TURN_CYC_INT = `ASR_TURN_CYC;
  localparam integer CYCLE_CYC_INT = `ASR_CYCLE_CYC;

  localparam [`ASR_CNT_W-1:0] RD_CYC = RD_CYC_INT[`ASR_CNT_W-1:0];
  localparam [`ASR_CNT_W-1:0] WR_CYC = WR_CYC_INT[`ASR_CNT_W-1:0];
  localparam [`ASR_CNT_W-1:0] TURN_CYC = TURN_CYC_INT[`ASR_CNT_W-1:0];
  localparam [`ASR_CNT_W-1:0] CYCLE_CYC = CYCLE_CYC_INT[`ASR_CNT_W-1:0];

  reg [2:0] state_reg;
  reg [`ASR_CNT_W-1:0] cnt_reg;
  reg [`ASR_CNT_W-1:0] gap_reg;
  reg [15:0] din_meta_reg;
  reg [15:0] din_sync_reg;

  // Zero-based count for a wait of n cycles
  function [`ASR_CNT_W-1:0] cnt_load;
    input [`ASR_CNT_W-1:0] n;
    begin
      cnt_load = n - 3'h1;
    end
  endfunction

  // Wait counter has run out
  function cnt_done;
    input [`ASR_CNT_W-1:0] c;
    begin
      cnt_done = (c == {`ASR_CNT_W{1'b0}});
    end
  endfunction

  // Unselected lanes float on the pins; return them as zero
  function [15:0] lane_keep;
    input [15:0] data;
    input [1:0] sel_n;
    begin
      lane_keep = {sel_n[1] ? 8'h00 : data[15:8], sel_n[0] ? 8'h00 : data[7:0]};
    end
  endfunction

  assign req_ready = (state_reg == ST_IDLE) && (gap_reg == 3'h0);

  // Two-stage sampler for the data pins; only the second stage is read
  always @(posedge clk_sys) begin
    if (reset) begin
      din_meta_reg <= 16'h0000;
      din_sync_reg <= 16'h0000;
    end else if (clk_en) begin
      din_meta_reg <= data_bus_in;
      din_sync_reg <= din_meta_reg;
    end
  end

  // Request sequencer and memory pin drivers
  always @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 3'h0;
      gap_reg <= 3'h0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      mem_addr <= 18'h00000;
      chip_select_n <= 1'b1;
      output_drive_n <= 1'b1;
      write_strobe_n <= 1'b1;
      low_byte_select_n <= 1'b1;
      high_byte_select_n <= 1'b1;
      data_bus_out <= 16'h0000;
      data_bus_oe_n <= 1'b1;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      if (gap_reg != 3'h0)
        gap_reg <= gap_reg - 3'h1;
      case (state_reg)
        ST_IDLE: begin
          if (req_valid && gap_reg == 3'h0) begin
            // Address and lanes set before the strobe falls
            mem_addr <= req_addr;
            chip_select_n <= 1'b0;
            low_byte_select_n <= ~req_be[0];
            high_byte_select_n <= ~req_be[1];
            gap_reg <= cnt_load(CYCLE_CYC);
            if (req_write) begin
              output_drive_n <= 1'b1;
              data_bus_out <= req_wdata;
              data_bus_oe_n <= 1'b0;
              state_reg <= ST_WSETUP;
            end else begin
              // Release the bus for a turnaround before enabling outputs
              data_bus_oe_n <= 1'b1;
              cnt_reg <= cnt_load(TURN_CYC);
              state_reg <= ST_RTURN;
            end
          end
        end
        ST_WSETUP: begin
          write_strobe_n <= 1'b0;
          cnt_reg <= cnt_load(WR_CYC);
          state_reg <= ST_WSTROBE;
        end
        ST_WSTROBE: begin
          // Strobe low long enough for pulse width plus turn-off; lane, address and data setup are not counted
          if (cnt_done(cnt_reg)) begin
            write_strobe_n <= 1'b1;
            state_reg <= ST_WEND;
          end else begin
            cnt_reg <= cnt_reg - 3'h1;
          end
        end
        ST_WEND: begin
          // Address, data and select held one cycle past the strobe edge
          chip_select_n <= 1'b1;
          low_byte_select_n <= 1'b1;
          high_byte_select_n <= 1'b1;
          data_bus_oe_n <= 1'b1;
          state_reg <= ST_IDLE;
        end
        ST_RTURN: begin
          if (cnt_done(cnt_reg)) begin
            output_drive_n <= 1'b0;
            cnt_reg <= cnt_load(RD_CYC);
            state_reg <= ST_RWAIT;
          end else begin
            cnt_reg <= cnt_reg - 3'h1;
          end
        end
        ST_RWAIT: begin
          // Access delay only; REND then waits the two synchroniser stages
          if (cnt_done(cnt_reg))
            state_reg <= ST_REND;
          else
            cnt_reg <= cnt_reg - 3'h1;
        end
        ST_REND: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h1) begin
            rsp_rdata <= lane_keep(din_sync_reg, {high_byte_select_n, low_byte_select_n});
            rsp_valid <= 1'b1;
            output_drive_n <= 1'b1;
            chip_select_n <= 1'b1;
            low_byte_select_n <= 1'b1;
            high_byte_select_n <= 1'b1;
            cnt_reg <= 3'h0;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // asr_ctrl

// ===== tb/asr_ctrl_assertions.sv
// Pin-sequence checker for the memory controller.
// Bound to asr_ctrl; sees only its ports.
`timescale 1ns/1ps
module asr_ctrl_assertions (
  input wire clk_sys, reset, req_ready, chip_select_n, output_drive_n, write_strobe_n,
  input wire rsp_valid, low_byte_select_n, high_byte_select_n, data_bus_oe_n,
  input wire [17:0] mem_addr,
  input wire [15:0] data_bus_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_addr_held: assert property (!chip_select_n && $past(!chip_select_n) |->
    $stable({mem_addr, low_byte_select_n, high_byte_select_n})) else $error("addr moved");
  chk_strobe_in_sel: assert property ($fell(write_strobe_n) |-> $past(!chip_select_n))
    else $error("strobe first");
  chk_wdata_stable: assert property (!write_strobe_n |-> !data_bus_oe_n && $stable(data_bus_out))
    else $error("data moved");
  chk_strobe_ends: assert property ($rose(write_strobe_n) |-> !chip_select_n && !data_bus_oe_n)
    else $error("no hold");
  chk_strobe_width: assert property ($fell(write_strobe_n) |=> write_strobe_n && !chip_select_n)
    else $error("strobe width");
  chk_no_fight: assert property (!output_drive_n |-> data_bus_oe_n) else $error("fight");
  chk_turn_gap: assert property ($fell(output_drive_n) |-> $past(data_bus_oe_n)) else $error("no gap");
  chk_busy_gap: assert property (!chip_select_n |-> !req_ready) else $error("ready early");
  cover property ($fell(write_strobe_n));
  cover property ($rose(rsp_valid));
  cover property ($fell(chip_select_n) && low_byte_select_n && high_byte_select_n);
endmodule // asr_ctrl_assertions

// ===== tb/asr_sram_model.sv
// Behavioural 256K x 16 static memory.
// Assumes controller pins wired straight; clk only paces the idle-bus pattern.
`timescale 1ns/1ps
module asr_sram_model (
  input wire clk, cs_n, oe_n, we_n, lb_n, hb_n, host_oe_n,
  input wire [17:0] addr,
  input wire [15:0] host_d,
  output wire [15:0] bus
);
  logic [15:0] mem [0:262143];
  logic [15:0] junk = 16'h5a3c;
  logic [15:0] drv;
  wire wr = !cs_n && !we_n;
  wire rd = !cs_n && !oe_n && we_n;
  always @(posedge clk) junk <= {junk[14:0], ~junk[15]};
  always @(negedge wr) begin
    if (!lb_n) mem[addr][7:0] = host_d[7:0];
    if (!hb_n) mem[addr][15:8] = host_d[15:8];
  end
  always @* begin
    drv[7:0] = rd && !lb_n ? mem[addr][7:0] : !host_oe_n ? host_d[7:0] : junk[7:0];
    drv[15:8] = rd && !hb_n ? mem[addr][15:8] : !host_oe_n ? host_d[15:8] : junk[15:8];
  end
  assign #6 bus = drv;
endmodule // asr_sram_model

// ===== tb/asr_ctrl_tb_top.sv
// Random write/read bench for the controller against the memory model.
// Assumes design, header, model and checker compiled together.
`timescale 1ns/1ps
module asr_ctrl_tb_top;
  logic clk_sys = 0, reset = 1, clk_en = 1, req_valid = 0, req_write = 0;
  logic [17:0] req_addr = 0, a;
  logic [15:0] req_wdata = 0, d;
  logic [1:0] req_be = 0, wb, rb;
  logic [31:0] seed = 32'h3c31;
  int bad_count = 0, n_tests = 0;
  wire req_ready, rsp_valid, chip_select_n, output_drive_n, write_strobe_n;
  wire low_byte_select_n, high_byte_select_n, data_bus_oe_n;
  wire [17:0] mem_addr;
  wire [15:0] rsp_rdata, data_bus_in, data_bus_out;
  asr_ctrl u_dut (.clk_sys, .reset, .clk_en, .req_valid, .req_write, .req_addr, .req_wdata, .req_be,
    .req_ready, .rsp_valid, .rsp_rdata, .mem_addr, .chip_select_n, .output_drive_n, .write_strobe_n,
    .low_byte_select_n, .high_byte_select_n, .data_bus_in, .data_bus_out, .data_bus_oe_n);
  asr_sram_model u_mem (.clk(clk_sys), .cs_n(chip_select_n), .oe_n(output_drive_n), .we_n(write_strobe_n),
    .lb_n(low_byte_select_n), .hb_n(high_byte_select_n), .host_oe_n(data_bus_oe_n), .addr(mem_addr),
    .host_d(data_bus_out), .bus(data_bus_in));
  initial forever #20 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] lanes(input logic [15:0] o, input logic [15:0] n, input logic [1:0] be);
    return {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
  endfunction
  task automatic close_out;
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Valid stays up after the take; the next request overwrites it
  task automatic xfer(input logic w, input logic [17:0] ad, input logic [15:0] wd, input logic [1:0] be);
    int n = 0;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= ad;
    req_wdata <= wd;
    req_be <= be;
    do @(negedge clk_sys); while (req_ready !== 1'b1 && ++n < 50);
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [17:0] ad, input logic [1:0] be, input logic [15:0] e);
    int n = 0;
    xfer(1'b0, ad, 16'h0000, be);
    req_valid <= 1'b0;
    do @(negedge clk_sys); while (rsp_valid !== 1'b1 && ++n < 20);
    chk("read latency", 16'h0005, 16'(n + 1));
    chk("read data", lanes(16'h0000, e, be), lanes(16'h0000, rsp_rdata, be));
    chk("unselected lanes", 16'h0000, lanes(16'h0000, rsp_rdata, ~be));
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      a = seed[17:0];
      d = seed[31:16];
      seed = xs(seed);
      wb = i < 4 ? i[1:0] : seed[1:0];
      rb = i < 4 ? 2'(3 - i) : seed[3:2];
      xfer(1'b1, a, d, 2'b11);
      xfer(1'b1, a, seed[31:16], wb);
      rd(a, rb, lanes(d, seed[31:16], wb));
    end
    close_out;
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    close_out;
  end
endmodule // asr_ctrl_tb_top
bind asr_ctrl asr_ctrl_assertions u_chk (.clk_sys, .reset, .req_ready, .chip_select_n, .output_drive_n,
  .write_strobe_n, .rsp_valid, .low_byte_select_n, .high_byte_select_n, .data_bus_oe_n, .mem_addr,
  .data_bus_out);
